// ===== logic/hsm_health_status_monitor.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - declare LOS per interface after 175 consecutive zero bits
// - clear LOS once ones density in a window reaches 12.5 percent
// - declare OOF when 2 of last 4 frame sync bits are errored
// - hold OOF until a reframe, then clear it
// - flag AIS per interface while unframed all ones are received
// - in ESF mode flag error rate above threshold, clear below it
// - flag received yellow alarm separately per interface
// - rank the seventeen conditions in fixed priority order
// - sample every ten seconds; on change update status and re-present top
// - report operational only when no condition is active
// - latch internal fault with 8-digit code until reset
// - latch download failure on interrupted download until reset
// - flag retry disabled only when a retry exceeds the maximum
// - flag master clock failure unless the internal clock is the selected source
// - flag management link down; on modem port only while connected
// - after five idle minutes switch to automatic top-only view
// - flag test in progress while any test is active
// - self-test keeps an 8 hex digit failure code and categories
// - self-test records memory failure on checksum mismatch
// - self-test records a failure per failed loopback circuit
// - self-test records alarm failure on AIS send or yellow detect fail
// - self-test records line-coding failure on B8ZS or LOS detect fail
// - on master clock failure switch timing to internal clock
module hsm_health_status_monitor #(
    parameter longint POLL_CYCLES = hsm_pkg::POLL_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // line inputs, bit 0 network, bit 1 dsx-1
    input  wire logic [1:0]  rxBitValid,
    input  wire logic [1:0]  rxBit,
    input  wire logic [1:0]  fsValid,
    input  wire logic [1:0]  fsErr,
    input  wire logic [1:0]  reframe,
    input  wire logic [1:0]  yellowIn,
    input  wire logic [15:0] errRate,
    // device conditions
    input  wire logic        faultEvt,
    input  wire logic [31:0] faultCode,
    input  wire logic        dlStart,
    input  wire logic        dlDone,
    input  wire logic        dlAbort,
    input  wire logic        alarmRetry,
    input  wire logic [7:0]  alarmRetryNum,
    input  wire logic        testActive,
    input  wire logic        modemConn,
    input  wire logic        mgmtLinkUp,
    input  wire logic        mclkFail,
    input  wire logic        keyActivity,
    // self-test results
    input  wire logic        stDone,
    input  wire logic [15:0] stChecksum,
    input  wire logic [15:0] stChecksumRef,
    input  wire logic [31:0] stLoopTx,
    input  wire logic [31:0] stLoopRx,
    input  wire logic        stAisTxFail,
    input  wire logic        stYellowFail,
    input  wire logic        stB8zsFail,
    input  wire logic        stLosDetFail,
    input  wire logic [31:0] stCode,
    // status outputs
    output logic [16:0]      statusVec,
    output logic [4:0]       topIdx,
    output logic             operational,
    output logic             redisplay,
    output logic             autoView,
    output logic             timingInternal
);
    // ==========================================================
    // registers
    logic [4:0]  ctrl_q;
    logic [15:0] errThr_q;
    logic [7:0]  retryMax_q;
    logic [16:0] live;
    logic [16:0] held_q;
    logic [6:0]  stRes_q;
    logic [31:0] stCode_q;
    logic [31:0] faultCode_q;
    logic        fault_q;
    logic        retry_q;
    logic        eer_q;
    logic        stFail_q;
    logic        redisp_q;
    logic [27:0] pollCnt_q;
    logic        pollTick;
    logic [5:0]  idleCnt_q;
    logic [1:0]  los;
    logic [1:0]  oof;
    logic [1:0]  ais;
    logic [2:0]  src;
    hsm_pkg::hsm_dl_t dl_q;

    assign src = ctrl_q[hsm_pkg::CTRL_SRC_LSB +: 3];

    // software-written configuration
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q     <= hsm_pkg::CTRL_RST;
            errThr_q   <= hsm_pkg::ERR_THR_RST;
            retryMax_q <= hsm_pkg::RETRY_MAX_RST;
        end else if (regWr) begin
            case (regAddr)
                hsm_pkg::OFS_CTRL:      ctrl_q     <= regWrData[4:0];
                hsm_pkg::OFS_ERR_THR:   errThr_q   <= regWrData[15:0];
                hsm_pkg::OFS_RETRY_MAX: retryMax_q <= regWrData[7:0];
                default:                ;
            endcase
        end
    end

    // read data in the cycle after the strobe only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 32'h0;
        end else if (!regRd) begin
            regRdData <= 32'h0;
        end else begin
            case (regAddr)
                hsm_pkg::OFS_CTRL:      regRdData <= {27'h0, ctrl_q};
                hsm_pkg::OFS_ERR_THR:   regRdData <= {16'h0, errThr_q};
                hsm_pkg::OFS_RETRY_MAX: regRdData <= {24'h0, retryMax_q};
                hsm_pkg::OFS_STATUS:    regRdData <= {15'h0, held_q};
                hsm_pkg::OFS_TOP:       regRdData <= {22'h0, autoView, operational, 3'h0, topIdx};
                hsm_pkg::OFS_ST_RES:    regRdData <= {24'h0, stFail_q, stRes_q};
                hsm_pkg::OFS_ST_CODE:   regRdData <= stCode_q;
                hsm_pkg::OFS_FAULT:     regRdData <= faultCode_q;
                hsm_pkg::OFS_LIVE:      regRdData <= {15'h0, live};
                default:                regRdData <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // per-interface line alarms
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            logic [7:0]  zeroRun_q;
            logic [2:0]  blkCnt_q;
            logic        blkOne_q;
            logic        los_q;
            logic [3:0]  fsHist_q;
            logic [3:0]  fsNext;
            logic        oof_q;
            logic [15:0] onesRun_q;
            logic        fsBad;

            assign fsBad  = fsValid[gi] && fsErr[gi];
            assign fsNext = {fsHist_q[2:0], fsBad};

            // zero run and ones-density window
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    zeroRun_q <= 8'h00;
                    blkCnt_q  <= 3'h0;
                    blkOne_q  <= 1'b0;
                    los_q     <= 1'b0;
                end else if (rxBitValid[gi]) begin
                    zeroRun_q <= rxBit[gi] ? 8'h00 : zeroRun_q + ((zeroRun_q != 8'hff) ? 8'h01 : 8'h00);
                    blkCnt_q  <= blkCnt_q + 3'h1;
                    blkOne_q  <= (blkCnt_q == 3'(hsm_pkg::DENS_WIN - 1)) ? 1'b0 : (blkOne_q | rxBit[gi]);
                    if (!rxBit[gi] && zeroRun_q == 8'(hsm_pkg::LOS_ZEROS - 1)) begin
                        los_q <= 1'b1;
                    end else if (blkCnt_q == 3'(hsm_pkg::DENS_WIN - 1) && (blkOne_q | rxBit[gi])) begin
                        los_q <= 1'b0;
                    end
                end
            end

            // frame sync error window, held until reframe
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    fsHist_q <= 4'h0;
                    oof_q    <= 1'b0;
                end else begin
                    if (fsValid[gi]) begin
                        fsHist_q <= fsNext;
                    end
                    if (fsBad && ($countones(fsNext) >= 2)) begin
                        oof_q <= 1'b1;
                    end else if (reframe[gi]) begin
                        oof_q    <= 1'b0;
                    end
                end
            end

            // unframed all-ones run
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    onesRun_q <= 16'h0000;
                end else if (rxBitValid[gi]) begin
                    onesRun_q <= !rxBit[gi] ? 16'h0000
                               : onesRun_q + ((onesRun_q != 16'hffff) ? 16'h0001 : 16'h0000);
                end
            end

            assign los[gi] = los_q;
            assign oof[gi] = oof_q;
            assign ais[gi] = oof_q && (onesRun_q >= hsm_pkg::AIS_ONES);

            property p_oof_clear;
                @(posedge clk) disable iff (sys_rst)
                reframe[gi] && !fsBad |=> !oof[gi];
            endproperty
            a_oof_clear : assert property (p_oof_clear) else $error("oof not cleared");

            property p_los_decl;
                @(posedge clk) disable iff (sys_rst)
                rxBitValid[gi] && !rxBit[gi] && zeroRun_q == 8'(hsm_pkg::LOS_ZEROS - 1)
                |=> los[gi];
            endproperty
            a_los_decl : assert property (p_los_decl) else $error("los not declared");
        end
    endgenerate

    // ==========================================================
    // device conditions
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eer_q <= 1'b0;
        end else if (!ctrl_q[hsm_pkg::CTRL_ESF_BIT]) begin
            eer_q <= 1'b0;
        end else if (errRate > errThr_q) begin
            eer_q <= 1'b1;
        end else if (errRate < errThr_q) begin
            eer_q <= 1'b0;
        end
    end

    // internal fault with its first code, sticky until reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q     <= 1'b0;
            faultCode_q <= 32'h0;
        end else if (faultEvt && !fault_q) begin
            fault_q     <= 1'b1;
            faultCode_q <= faultCode;
        end
    end

    // download tracking
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dl_q <= hsm_pkg::DL_IDLE;
        end else begin
            case (dl_q)
                hsm_pkg::DL_IDLE: dl_q <= dlStart ? hsm_pkg::DL_BUSY : hsm_pkg::DL_IDLE;
                hsm_pkg::DL_BUSY: begin
                    if (dlAbort) begin
                        dl_q <= hsm_pkg::DL_FAIL;
                    end else if (dlDone) begin
                        dl_q <= hsm_pkg::DL_IDLE;
                    end
                end
                hsm_pkg::DL_FAIL: dl_q <= hsm_pkg::DL_FAIL;
                default:          dl_q <= hsm_pkg::DL_IDLE;
            endcase
        end
    end

    // alarm retry past the maximum
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            retry_q <= 1'b0;
        end else if (alarmRetry && alarmRetryNum > retryMax_q) begin
            retry_q <= 1'b1;
        end
    end

    // clock fallback
    assign timingInternal = (src == hsm_pkg::SRC_INTERNAL) || mclkFail;

    // ==========================================================
    // self-test capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stRes_q  <= 7'h00;
            stCode_q <= 32'h0;
            stFail_q <= 1'b0;
        end else if (stDone) begin
            stRes_q[hsm_pkg::ST_MEM] <= stChecksum != stChecksumRef;
            for (int k = 0; k < 4; k++) begin
                stRes_q[hsm_pkg::ST_LOOP_LSB + k] <= stLoopTx[8*k +: 8] != stLoopRx[8*k +: 8];
            end
            stRes_q[hsm_pkg::ST_ALARM] <= stAisTxFail || stYellowFail;
            stRes_q[hsm_pkg::ST_B8ZS]  <= stB8zsFail || stLosDetFail;
            stCode_q <= stCode;
            stFail_q <= (stChecksum != stChecksumRef) || (stLoopTx != stLoopRx) || stAisTxFail
                        || stYellowFail || stB8zsFail || stLosDetFail || (stCode != 32'h0);
        end
    end

    // ==========================================================
    // live condition vector in priority order
    always_comb begin
        live = 17'h0;
        live[hsm_pkg::C_LOS_NET] = los[0];
        live[hsm_pkg::C_LOS_DSX] = los[1];
        live[hsm_pkg::C_OOF_NET] = oof[0];
        live[hsm_pkg::C_OOF_DSX] = oof[1];
        live[hsm_pkg::C_AIS_NET] = ais[0];
        live[hsm_pkg::C_AIS_DSX] = ais[1];
        live[hsm_pkg::C_EER]     = eer_q;
        live[hsm_pkg::C_YEL_NET] = yellowIn[0];
        live[hsm_pkg::C_YEL_DSX] = yellowIn[1];
        live[hsm_pkg::C_SELFTST] = stFail_q;
        live[hsm_pkg::C_FAULT]   = fault_q;
        live[hsm_pkg::C_DLFAIL]  = dl_q == hsm_pkg::DL_FAIL;
        live[hsm_pkg::C_RETRY]   = retry_q;
        live[hsm_pkg::C_TEST]    = testActive;
        live[hsm_pkg::C_MODEM]   = modemConn;
        live[hsm_pkg::C_MCLK]    = mclkFail && (src != hsm_pkg::SRC_INTERNAL);
        live[hsm_pkg::C_MGMT]    = !mgmtLinkUp
                                   && (!ctrl_q[hsm_pkg::CTRL_MODEM_BIT] || modemConn);
    end

    // ten-second poll timer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pollCnt_q <= 28'h0;
        end else begin
            pollCnt_q <= pollTick ? 28'h0 : pollCnt_q + 28'h1;
        end
    end
    assign pollTick = pollCnt_q == 28'(POLL_CYCLES - 1);

    // held status updated on change at a poll
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_q   <= 17'h0;
            redisp_q <= 1'b0;
        end else begin
            redisp_q <= pollTick && (live != held_q);
            if (pollTick && (live != held_q)) begin
                held_q <= live;
            end
        end
    end

    // key idle counted in poll periods
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idleCnt_q <= 6'h0;
        end else if (keyActivity) begin
            idleCnt_q <= 6'h0;
        end else if (pollTick && idleCnt_q != hsm_pkg::IDLE_POLLS) begin
            idleCnt_q <= idleCnt_q + 6'h1;
        end
    end

    // priority encode of the held vector
    always_comb begin
        topIdx = hsm_pkg::IDX_OPER;
        for (int k = hsm_pkg::NCOND - 1; k >= 0; k--) begin
            if (held_q[k]) begin
                topIdx = 5'(k);
            end
        end
    end

    assign statusVec   = held_q;
    assign operational = held_q == 17'h0;
    assign redisplay   = redisp_q;
    assign autoView    = idleCnt_q == hsm_pkg::IDLE_POLLS;

    // ==========================================================
    // checks
    property p_eer_set;
        @(posedge clk) disable iff (sys_rst)
        ctrl_q[hsm_pkg::CTRL_ESF_BIT] && errRate > errThr_q |=> live[hsm_pkg::C_EER];
    endproperty
    a_eer_set : assert property (p_eer_set) else $error("eer not raised");

    property p_poll;
        @(posedge clk) disable iff (sys_rst)
        pollTick && live != held_q |=> redisplay && statusVec == $past(live);
    endproperty
    a_poll : assert property (p_poll) else $error("poll did not update");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        !pollTick |=> $stable(statusVec) && !redisplay;
    endproperty
    a_hold : assert property (p_hold) else $error("status changed off poll");

    property p_oper;
        @(posedge clk) disable iff (sys_rst)
        operational |-> statusVec == 17'h0 && topIdx == hsm_pkg::IDX_OPER;
    endproperty
    a_oper : assert property (p_oper) else $error("operational with condition");

    property p_fault;
        @(posedge clk) disable iff (sys_rst)
        faultEvt && !fault_q |=> live[10] && faultCode_q == $past(faultCode) ##1 live[10];
    endproperty
    a_fault : assert property (p_fault) else $error("fault not latched");

    property p_dl;
        @(posedge clk) disable iff (sys_rst)
        dl_q == hsm_pkg::DL_BUSY && dlAbort |=> live[11] [*3];
    endproperty
    a_dl : assert property (p_dl) else $error("download fail not held");

    property p_mclk;
        @(posedge clk) disable iff (sys_rst)
        mclkFail |-> timingInternal && (live[15] == (src != hsm_pkg::SRC_INTERNAL));
    endproperty
    a_mclk : assert property (p_mclk) else $error("clock fallback missing");

    property p_mgmt;
        @(posedge clk) disable iff (sys_rst)
        ctrl_q[1] && !modemConn |-> !live[16];
    endproperty
    a_mgmt : assert property (p_mgmt) else $error("mgmt down without modem");

    property p_mem;
        @(posedge clk) disable iff (sys_rst)
        stDone && stChecksum != stChecksumRef |=> stRes_q[0] && stFail_q;
    endproperty
    a_mem : assert property (p_mem) else $error("memory fail not recorded");

    c_redisp : cover property (@(posedge clk) disable iff (sys_rst) redisplay);
    c_auto   : cover property (@(posedge clk) disable iff (sys_rst) autoView);
    c_aisdsx : cover property (@(posedge clk) disable iff (sys_rst) ais[1] && oof[1]);
    c_dlfail : cover property (@(posedge clk) disable iff (sys_rst) dl_q == hsm_pkg::DL_FAIL);
endmodule : hsm_health_status_monitor

// ===== logic/hsm_pkg.sv
package hsm_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_ERR_THR   = 8'h04;
    localparam logic [7:0] OFS_RETRY_MAX = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_TOP       = 8'h10;
    localparam logic [7:0] OFS_ST_RES    = 8'h14;
    localparam logic [7:0] OFS_ST_CODE   = 8'h18;
    localparam logic [7:0] OFS_FAULT     = 8'h1c;
    localparam logic [7:0] OFS_LIVE      = 8'h20;
    // ==========================================================
    // control fields and reset values
    localparam int CTRL_ESF_BIT   = 0;
    localparam int CTRL_MODEM_BIT = 1;
    localparam int CTRL_SRC_LSB   = 2;
    localparam logic [2:0]  SRC_INTERNAL  = 3'h3;
    localparam logic [4:0]  CTRL_RST      = 5'h00;
    localparam logic [15:0] ERR_THR_RST   = 16'h0010;
    localparam logic [7:0]  RETRY_MAX_RST = 8'h03;
    localparam int TOP_OPER_BIT = 8;
    localparam int TOP_AUTO_BIT = 9;
    // ==========================================================
    // condition indices, highest priority first
    localparam int NCOND = 17;
    localparam int C_LOS_NET = 0;
    localparam int C_LOS_DSX = 1;
    localparam int C_OOF_NET = 2;
    localparam int C_OOF_DSX = 3;
    localparam int C_AIS_NET = 4;
    localparam int C_AIS_DSX = 5;
    localparam int C_EER     = 6;
    localparam int C_YEL_NET = 7;
    localparam int C_YEL_DSX = 8;
    localparam int C_SELFTST = 9;
    localparam int C_FAULT   = 10;
    localparam int C_DLFAIL  = 11;
    localparam int C_RETRY   = 12;
    localparam int C_TEST    = 13;
    localparam int C_MODEM   = 14;
    localparam int C_MCLK    = 15;
    localparam int C_MGMT    = 16;
    localparam logic [4:0] IDX_OPER = 5'h11;
    // self-test result bits
    localparam int ST_MEM = 0;
    localparam int ST_LOOP_LSB = 1;
    localparam int ST_ALARM = 5;
    localparam int ST_B8ZS = 6;
    // ==========================================================
    // timing
    localparam int LOS_ZEROS     = 175;
    localparam int DENS_WIN      = 8;
    localparam logic [15:0] AIS_ONES = 16'h0800;
    localparam longint CLK_HZ    = 20000000;
    localparam longint POLL_SEC  = 10;
    localparam longint POLL_CYC  = POLL_SEC * CLK_HZ;
    localparam int IDLE_SEC      = 300;
    localparam logic [5:0] IDLE_POLLS = 6'(IDLE_SEC / POLL_SEC);
    // download tracking states
    typedef enum logic [2:0] {
        DL_IDLE = 3'b001,
        DL_BUSY = 3'b010,
        DL_FAIL = 3'b100
    } hsm_dl_t;
endpackage : hsm_pkg

// ===== verif/hsm_line_model.sv
`timescale 1ns/1ps
// ==========================================
// far-side line model: bit source per interface
module hsm_line_model (
    // clock
    input  wire logic       clk,
    // control from bench
    input  wire logic [1:0] lineEn,
    input  wire logic [1:0] lineOnes,
    // line outputs
    output logic      [1:0] rxBitValid,
    output logic      [1:0] rxBit
);
    logic idleTgl_q = 1'b0;
    // idle data line wanders, never holds last bit
    always_ff @(posedge clk) begin
        idleTgl_q <= ~idleTgl_q;
    end
    // one bit per cycle while enabled
    assign rxBitValid = lineEn;
    assign rxBit      = (lineEn & lineOnes) | (~lineEn & {2{idleTgl_q}});
endmodule : hsm_line_model

// ===== verif/health_status_monitor_tb.sv
`timescale 1ns/1ps
module health_status_monitor_tb;
    logic clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00, alarmRetryNum = 8'h00;
    logic [31:0] regWrData = '0, faultCode = '0, regRdData, d;
    logic [1:0] rxBitValid, rxBit, lineEn = 2'h0, lineOnes = 2'h0, yellowIn = 2'h0;
    logic [15:0] errRate = 16'h0000, stCk = 16'h0000;
    logic [7:0] pv = 8'h00; // pulses: fault, dl start/done/abort, retry, selftest, reframe x2
    logic [1:0] fsValid = 2'h0, fsErr = 2'h0;
    logic [3:0] stFl = 4'h0; // ais tx, yellow, b8zs, los detect failures
    logic [31:0] stLoopRx = '0, stCode = '0;
    logic testActive = 0, modemConn = 0, mgmtLinkUp = 1, mclkFail = 0, keyActivity = 0;
    logic [16:0] statusVec;
    logic [4:0] topIdx;
    logic operational, redisplay, autoView, timingInternal;
    int n_errors = 0, cmp_count = 0;
    logic [5:0] rowIn [6] = '{6'h12, 6'h22, 6'h0a, 6'h06, 6'h03, 6'h00};
    logic [16:0] rowExp [6] = '{17'h80, 17'h100, 17'h2000, 17'h4000, 17'h8000, 17'h10000};
    // ==========================================
    // clock and instances
    always #25 clk = ~clk;
    hsm_line_model line_u (.clk, .lineEn, .lineOnes, .rxBitValid, .rxBit);
    hsm_health_status_monitor #(.POLL_CYCLES(50)) dut_u (
        .clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .rxBitValid, .rxBit, .fsValid, .fsErr, .reframe(pv[7:6]), .yellowIn,
        .errRate, .faultEvt(pv[0]), .faultCode, .dlStart(pv[1]), .dlDone(pv[2]),
        .dlAbort(pv[3]), .alarmRetry(pv[4]), .alarmRetryNum, .testActive, .modemConn,
        .mgmtLinkUp, .mclkFail, .keyActivity, .stDone(pv[5]), .stChecksum(stCk),
        .stChecksumRef(16'h0), .stLoopTx('0), .stLoopRx, .stAisTxFail(stFl[0]),
        .stYellowFail(stFl[1]), .stB8zsFail(stFl[2]), .stLosDetFail(stFl[3]), .stCode,
        .statusVec, .topIdx, .operational, .redisplay, .autoView, .timingInternal);
    // ==========================================
    // shared tasks
    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= v; end
        @(posedge clk) regWr <= 1'b0;
    endtask : wr
    task automatic pulse(input int k);
        @(posedge clk) pv[k] <= 1'b1;
        @(posedge clk) pv[k] <= 1'b0;
    endtask : pulse
    task automatic selftest_view(input logic [15:0] ck, input logic [31:0] rx, input logic [3:0] fl,
                         input logic [31:0] cd, input logic [7:0] e);
        @(posedge clk) begin stCk <= ck; stLoopRx <= rx; stFl <= fl; stCode <= cd; end
        pulse(5);
        rd(hsm_pkg::OFS_ST_RES); chk("stRes", {24'h0, e}, d);
        rd(hsm_pkg::OFS_ST_CODE); chk("stCode", cd, d);
        rd(hsm_pkg::OFS_LIVE); chk("stLive", e[7], d[9]);
    endtask : selftest_view
    // ==========================================
    // main sequence
    initial begin
        @(posedge clk);
        #1 chk("topRst", {27'h0, hsm_pkg::IDX_OPER}, topIdx);
        chk("operRst", 1, operational);
        @(posedge clk) sys_rst <= 1'b0;
        rd(hsm_pkg::OFS_ERR_THR); chk("thr", 32'h10, d);
        rd(hsm_pkg::OFS_RETRY_MAX); chk("rmax", 32'h3, d);
        rd(8'h40); chk("unmapped", 32'h0, d);
        // table of level conditions
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) {yellowIn, testActive, modemConn, mgmtLinkUp, mclkFail} <= rowIn[i];
            rd(hsm_pkg::OFS_LIVE); chk("live", rowExp[i], d);
            chk("tint", rowIn[i][0], timingInternal);
        end
        @(posedge clk) {yellowIn, mgmtLinkUp, mclkFail} <= 4'b0010;
        wr(hsm_pkg::OFS_CTRL, 32'h1);
        @(posedge clk) errRate <= 16'h0011;
        rd(hsm_pkg::OFS_LIVE); chk("eerSet", 1, d[6]);
        @(posedge clk) errRate <= 16'h000f;
        rd(hsm_pkg::OFS_LIVE); chk("eerClr", 0, d[6]);
        // zero run on network side
        @(posedge clk) lineEn <= 2'b01;
        repeat (174) @(posedge clk);
        lineEn <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("los174", 0, d[0]);
        @(posedge clk) lineEn <= 2'b01;
        @(posedge clk) lineEn <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("los175", 1, d[0]);
        for (int t = 0; t < 200 && !(redisplay === 1'b1 && statusVec[0] === 1'b1); t++)
            @(negedge clk);
        chk("redisp", 1, redisplay);
        chk("held", 17'h1, statusVec);
        chk("top", 0, topIdx);
        @(posedge clk) begin lineEn <= 2'b01; lineOnes <= 2'b01; end
        repeat (8) @(posedge clk);
        lineEn <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("losClr", 0, d[0]);
        // frame sync errors and all ones on the dsx-1 side
        @(posedge clk) begin fsValid <= 2'b10; fsErr <= 2'b10; end
        @(posedge clk) fsValid <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("oof1", 0, d[3]);
        @(posedge clk) fsValid <= 2'b10;
        @(posedge clk) fsValid <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("oof2", 1, d[3]);
        @(posedge clk) begin lineEn <= 2'b10; lineOnes <= 2'b10; end
        repeat (2048) @(posedge clk);
        lineEn <= 2'b00;
        rd(hsm_pkg::OFS_LIVE); chk("ais", 3'h5, d[5:3]);
        pulse(7);
        rd(hsm_pkg::OFS_LIVE); chk("reframe", 0, d[5:3]);
        // self-test categories and code
        selftest_view(16'h0001, 32'h00ff0000, 4'h5, 32'h0badc0de, 8'he9);
        selftest_view(16'h0000, 32'h000000ff, 4'ha, 32'h00000000, 8'he2);
        selftest_view(16'h0000, 32'hff00ff00, 4'h0, 32'h00c0ffee, 8'h94);
        selftest_view(16'h0000, 32'h00000000, 4'h0, 32'h00000000, 8'h00);
        // latched device conditions
        faultCode <= 32'h1234abcd;
        pulse(0);
        faultCode <= 32'h00000001;
        pulse(0);
        rd(hsm_pkg::OFS_FAULT); chk("fcode", 32'h1234abcd, d);
        alarmRetryNum <= 8'h03;
        pulse(4);
        pulse(1);
        pulse(2);
        pulse(3);
        rd(hsm_pkg::OFS_LIVE); chk("retry3", 0, d[12]);
        chk("dlDone", 0, d[11]);
        alarmRetryNum <= 8'h04;
        pulse(4);
        pulse(1);
        pulse(3);
        rd(hsm_pkg::OFS_LIVE); chk("latch", 3'h7, d[12:10]);
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        rd(hsm_pkg::OFS_LIVE); chk("latchRst", 0, d[12:10]);
        #1 chk("statRst", 0, statusVec);
        // key idle for thirty polls
        repeat (1400) @(posedge clk);
        #1 chk("autoEarly", 0, autoView);
        for (int t = 0; t < 200 && autoView !== 1'b1; t++) @(negedge clk);
        chk("auto", 1, autoView);
        rd(hsm_pkg::OFS_TOP); chk("topReg", 32'h311, d);
        @(posedge clk) keyActivity <= 1'b1;
        @(posedge clk) keyActivity <= 1'b0;
        #1 chk("autoKey", 0, autoView);
        summarize();
    end
endmodule : health_status_monitor_tb
